// file: logic/relay_counter_regs.svh
// register map, field layout and timing constants of the counter relay block
`ifndef RELAY_COUNTER_REGS_SVH
`define RELAY_COUNTER_REGS_SVH

// instance count and value widths
`define NUM_CNT 16
`define VAL_W 16
`define GATE_W 24
`define ADDR_W 8

// value range of an actual value or a setpoint
`define ACT_MIN 16'h0000
`define ACT_MAX 16'h7D00

// instances that may keep their value, bit i is instance i+1
`define RETAIN_ALLOWED 16'hF0F0

// instance index tied to each fast input
`define FREQ_IDX_A 4'hE
`define FREQ_IDX_B 4'hF

// byte offsets
`define OFF_RETAIN 8'h00
`define OFF_MODE 8'h04
`define OFF_CONTACT 8'h08
`define OFF_SETPOINT 8'h40
`define OFF_ACTUAL 8'h80
`define OFF_REGION_MASK 8'hC0

// reset values of the software registers
`define RETAIN_RESET 16'h0000
`define MODE_RESET 2'h0

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// gate time of the frequency measurement
`define CLK_HZ 10000000
`define GATE_TIME_MS 1000
// divide first so the product stays inside a 32-bit int
`define GATE_CYCLES ((`CLK_HZ / 1000) * `GATE_TIME_MS)

`endif

// file: logic/relay_counter_pkg.sv
// types shared by the counter relay block
`include "relay_counter_regs.svh"
package relay_counter_pkg;

   // coils driven by the program, bit i is instance i+1
   typedef struct packed {
      logic [`NUM_CNT-1:0] count;
      logic [`NUM_CNT-1:0] direction;
      logic [`NUM_CNT-1:0] clear;
   } coil_bus_t;

   // axi4-lite master to slave
   typedef struct packed {
      logic awvalid;
      logic [`ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`ADDR_W-1:0] araddr;
      logic rready;
   } axi_req_t;

   // axi4-lite slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;

   // read answer
   typedef struct packed {
      logic [1:0] resp;
      logic [31:0] data;
   } rd_result_t;

   // whole state of the block
   typedef struct packed {
      logic [`NUM_CNT-1:0][`VAL_W-1:0] setpoint;
      logic [`NUM_CNT-1:0][`VAL_W-1:0] actual;
      logic [`NUM_CNT-1:0] count_seen;
      logic [`NUM_CNT-1:0] clear_seen;
      logic [`NUM_CNT-1:0] contact;
      logic [`NUM_CNT-1:0] retain;
      logic [1:0] freq_mode;
      logic [1:0] pin_meta;
      logic [1:0] pin_stable;
      logic [1:0] pin_prev;
      logic [1:0][`GATE_W-1:0] gate;
      logic [1:0][`VAL_W-1:0] pulses;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

endpackage : relay_counter_pkg

// file: logic/relay_updown_freq_counter.sv
// sixteen up/down counters, two of them usable as frequency counters
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "relay_counter_regs.svh"

// Function
// - actual value stays within zero to 32000
// - hold at limit until direction changes
// - contact set when actual at least setpoint
// - contact clears at once below setpoint
// - no pulses, actual value unchanged
// - clear coil forces actual value to zero
// - retentive value kept over stop, supply loss
// - retentive counter resumes from stored value
// - retention only instances five-eight, thirteen-sixteen
// - fast inputs wired to instances fifteen, sixteen
// - frequency counted over one-second gate
// - fast contact transferred once per cycle
// - frequency mode ignores direction coil
// - frequency measured only while count coil set
// - clear coil zeroes frequency actual value
// - rising count coil edge changes value by one
// - direction coil off counts up, on down
// - setpoint constant from zero to 32000
// - removing enable zeroes frequency actual value
module relay_updown_freq_counter #(
   parameter int GATE_CYCLES = `GATE_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // program cycle side
   input wire logic cycle_strobe_in,
   input wire logic run_mode_in,
   input wire relay_counter_pkg::coil_bus_t coils_in,
   output logic [`NUM_CNT-1:0] contact_out,
   // fast digital input pins
   input wire logic fast_input_a_in,
   input wire logic fast_input_b_in,
   // register bus
   input wire relay_counter_pkg::axi_req_t axi_req_in,
   output var relay_counter_pkg::axi_rsp_t axi_rsp_out
);
   import relay_counter_pkg::*;

   // last clock of a measuring gate
   localparam logic [`GATE_W-1:0] GATE_LAST = `GATE_W'(GATE_CYCLES - 1);

   state_t s_q;
   state_t s_d;
   logic wr_go;
   logic rd_go;
   logic cycle_go;
   logic [1:0] freq_idle;
   logic [1:0] pin_rise;
   logic [`VAL_W-1:0] wr_val;
   rd_result_t rd_res;

   // instance index served by frequency slot f
   function automatic int freq_index(input int f);
      freq_index = (f == 0) ? int'(`FREQ_IDX_A) : int'(`FREQ_IDX_B);
   endfunction : freq_index

   // true when the instance works as a frequency counter
   function automatic logic is_freq(input logic [1:0] mode, input int idx);
      is_freq = (idx == freq_index(0) && mode[0])
         || (idx == freq_index(1) && mode[1]);
   endfunction : is_freq

   // limit a value to the counting range
   function automatic logic [`VAL_W-1:0] clamp(input logic [`VAL_W-1:0] v);
      clamp = (v > `ACT_MAX) ? `ACT_MAX : v;
   endfunction : clamp

   // merge the low two byte lanes of a write into an old value
   function automatic logic [`VAL_W-1:0] merge16(input logic [`VAL_W-1:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      merge16 = old;
      if (strb[0]) begin
         merge16[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merge16[15:8] = data[15:8];
      end
   endfunction : merge16

   // address falls in the setpoint block
   function automatic logic in_setpoints(input logic [`ADDR_W-1:0] a);
      in_setpoints = ((a & `OFF_REGION_MASK) == `OFF_SETPOINT);
   endfunction : in_setpoints

   // address falls in the actual value block
   function automatic logic in_actuals(input logic [`ADDR_W-1:0] a);
      in_actuals = ((a & `OFF_REGION_MASK) == `OFF_ACTUAL);
   endfunction : in_actuals

   // instance picked by a setpoint or actual address
   function automatic logic [3:0] reg_index(input logic [`ADDR_W-1:0] a);
      reg_index = a[5:2];
   endfunction : reg_index

   // one saturating count step, no wrap at either end
   function automatic logic [`VAL_W-1:0] count_step(input logic [`VAL_W-1:0] v,
         input logic down);
      count_step = v;
      if (down) begin
         if (v != `ACT_MIN) begin
            count_step = v - 16'h0001;
         end
      end else if (v < `ACT_MAX) begin
         count_step = v + 16'h0001;
      end
   endfunction : count_step

   // contact level for an actual value against its setpoint
   function automatic logic contact_of(input logic [`VAL_W-1:0] act,
         input logic [`VAL_W-1:0] sp);
      contact_of = (act >= sp);
   endfunction : contact_of

   // decode a read address into data and response
   function automatic rd_result_t read_word(input state_t s, input logic [`ADDR_W-1:0] a);
      rd_result_t r;
      r.resp = `RESP_OKAY;
      r.data = 32'h0000_0000;
      if (in_setpoints(a)) begin
         r.data[`VAL_W-1:0] = s.setpoint[reg_index(a)];
      end else if (in_actuals(a)) begin
         r.data[`VAL_W-1:0] = s.actual[reg_index(a)];
      end else if (a == `OFF_RETAIN) begin
         r.data[`VAL_W-1:0] = s.retain;
      end else if (a == `OFF_MODE) begin
         r.data[1:0] = s.freq_mode;
      end else if (a == `OFF_CONTACT) begin
         r.data[`NUM_CNT-1:0] = s.contact;
      end else begin
         r.resp = `RESP_SLVERR;
      end
      read_word = r;
   endfunction : read_word

   // bus handshakes, a write needs address and data together
   always_comb begin
      wr_go = axi_req_in.awvalid & axi_req_in.wvalid & ~s_q.bvalid;
      rd_go = axi_req_in.arvalid & ~s_q.rvalid;
      // program cycle evaluated only in run mode
      cycle_go = cycle_strobe_in & run_mode_in;
      axi_rsp_out.awready = wr_go;
      axi_rsp_out.wready = wr_go;
      axi_rsp_out.arready = rd_go;
      axi_rsp_out.bvalid = s_q.bvalid;
      axi_rsp_out.bresp = s_q.bresp;
      axi_rsp_out.rvalid = s_q.rvalid;
      axi_rsp_out.rdata = s_q.rdata;
      axi_rsp_out.rresp = s_q.rresp;
   end

   // next state of the whole block
   always_comb begin
      s_d = s_q;
      wr_val = 16'h0000;
      rd_res = '0;
      freq_idle = 2'b00;

      // fast pins pass two flops, edges seen after the second
      s_d.pin_meta = {fast_input_b_in, fast_input_a_in};
      s_d.pin_stable = s_q.pin_meta;
      s_d.pin_prev = s_q.pin_stable;
      pin_rise = s_q.pin_stable & ~s_q.pin_prev;

      // stop mode drops values that are not retentive; run low also
      // stands for supply loss, so retentive values must survive it
      if (!run_mode_in) begin
         for (int i = 0; i < `NUM_CNT; i++) begin
            if (!s_q.retain[i] && !is_freq(s_q.freq_mode, i)) begin
               s_d.actual[i] = `ACT_MIN;
            end
         end
      end

      // ordinary counters act once per program cycle; coils are
      // levels, so the count edge is found against the last strobe
      if (cycle_go) begin
         for (int i = 0; i < `NUM_CNT; i++) begin
            if (!is_freq(s_q.freq_mode, i)) begin
               // clear is checked first so it beats a count edge
               if (coils_in.clear[i]) begin
                  s_d.actual[i] = `ACT_MIN;
               end else if (coils_in.count[i] && !s_q.count_seen[i]) begin
                  s_d.actual[i] = count_step(s_q.actual[i], coils_in.direction[i]);
               end
               // compare the new value so a drop clears at once
               s_d.contact[i] = contact_of(s_d.actual[i], s_q.setpoint[i]);
            end else begin
               // frequency result handed over once per cycle, so it may lag
               s_d.contact[i] = contact_of(s_q.actual[i], s_q.setpoint[i]);
            end
         end
         s_d.count_seen = coils_in.count;
         s_d.clear_seen = coils_in.clear;
      end

      // frequency counters run on the clock, apart from the program
      for (int f = 0; f < 2; f++) begin
         int idx;
         idx = freq_index(f);
         // enable and clear are the coils latched at the last strobe
         freq_idle[f] = !s_q.freq_mode[f] || !run_mode_in || !s_q.count_seen[idx]
            || s_q.clear_seen[idx];
         // direction coil is never read here; idle slot stays at zero
         if (freq_idle[f]) begin
            s_d.gate[f] = '0;
            s_d.pulses[f] = 16'h0000;
            if (s_q.freq_mode[f]) begin
               s_d.actual[idx] = `ACT_MIN;
            end
         end else if (s_q.gate[f] == GATE_LAST) begin
            // gate closed, pulses in one second give hertz
            s_d.actual[idx] = clamp(s_q.pulses[f] + {15'h0000, pin_rise[f]});
            s_d.pulses[f] = 16'h0000;
            s_d.gate[f] = '0;
         end else begin
            s_d.gate[f] = s_q.gate[f] + `GATE_W'(1);
            if (pin_rise[f] && s_q.pulses[f] < `ACT_MAX) begin
               s_d.pulses[f] = s_q.pulses[f] + 16'h0001;
            end
         end
      end

      // write response retires before a new write is taken
      if (s_q.bvalid && axi_req_in.bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_d.bvalid = 1'b1;
         s_d.bresp = `RESP_OKAY;
         // setpoints are clamped so no instance can hold an unreachable one
         if (in_setpoints(axi_req_in.awaddr)) begin
            wr_val = merge16(s_q.setpoint[reg_index(axi_req_in.awaddr)], axi_req_in.wdata,
               axi_req_in.wstrb);
            s_d.setpoint[reg_index(axi_req_in.awaddr)] = clamp(wr_val);
         end else if (in_actuals(axi_req_in.awaddr)) begin
            s_d.bresp = `RESP_OKAY; // actual values are read only
         end else if (axi_req_in.awaddr == `OFF_RETAIN) begin
            // bits of fixed instances never stick
            wr_val = merge16(s_q.retain, axi_req_in.wdata, axi_req_in.wstrb);
            s_d.retain = wr_val & `RETAIN_ALLOWED;
         end else if (axi_req_in.awaddr == `OFF_MODE) begin
            // only the two frequency slots have a mode bit
            wr_val = merge16({14'h0000, s_q.freq_mode}, axi_req_in.wdata,
               axi_req_in.wstrb);
            s_d.freq_mode = wr_val[1:0];
         end else if (axi_req_in.awaddr == `OFF_CONTACT) begin
            s_d.bresp = `RESP_OKAY; // contacts are read only
         end else begin
            s_d.bresp = `RESP_SLVERR;
         end
      end

      // read data registered one cycle after the address
      if (s_q.rvalid && axi_req_in.rready) begin
         s_d.rvalid = 1'b0;
      end
      if (rd_go) begin
         rd_res = read_word(s_q, axi_req_in.araddr);
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_res.data;
         s_d.rresp = rd_res.resp;
      end
   end

   // state register; a reset clears retentive values too, so supply
   // loss is carried by the run input and not by this reset
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // contacts straight from their flops
   for (genvar g = 0; g < `NUM_CNT; g++) begin : g_contact
      assign contact_out[g] = s_q.contact[g];
   end

endmodule : relay_updown_freq_counter
`default_nettype wire

// file: verif/relay_counter_properties.sv
// assertion checker bound to the counter relay block
`timescale 1ns/1ps
`default_nettype none
`include "relay_counter_regs.svh"
module relay_counter_checker (
   // watched ports
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic cycle_strobe_in,
   input wire logic run_mode_in,
   input wire logic [`NUM_CNT-1:0] contact_out,
   input wire relay_counter_pkg::axi_req_t axi_req_in,
   input wire relay_counter_pkg::axi_rsp_t axi_rsp_out
);
   import relay_counter_pkg::*;
   logic [`ADDR_W-1:0] ra_q;
   // address of the read under way
   always_ff @(posedge clk_in) begin
      if (axi_req_in.arvalid && axi_rsp_out.arready && !axi_rsp_out.rvalid) begin
         ra_q <= axi_req_in.araddr;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // bus transfers taken
   sequence wr_take;
      axi_req_in.awvalid && axi_req_in.wvalid && axi_rsp_out.awready && !axi_rsp_out.bvalid;
   endsequence
   sequence rd_take;
      axi_req_in.arvalid && axi_rsp_out.arready && !axi_rsp_out.rvalid;
   endsequence
   AST_WR_ANSWER: assert property (wr_take |=> axi_rsp_out.bvalid)
      else $error("write not answered next cycle");
   AST_RD_ANSWER: assert property (rd_take |=> axi_rsp_out.rvalid)
      else $error("read not answered next cycle");
   AST_B_STANDS: assert property (axi_rsp_out.bvalid && !axi_req_in.bready
      |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp)) else $error("write answer dropped");
   AST_R_STANDS: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
      |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata)) else $error("read answer dropped");
   AST_RETAIN_MASK: assert property (
      axi_rsp_out.rvalid && ra_q == `OFF_RETAIN |-> (axi_rsp_out.rdata & 32'hFFFF0F0F) == 32'h0)
      else $error("retention set on a fixed instance");
   AST_VALUE_RANGE: assert property (
      axi_rsp_out.rvalid && ra_q[7:6] inside {2'h1, 2'h2} |-> axi_rsp_out.rdata <= 32'h7D00)
      else $error("value above upper limit");
   AST_UNMAPPED: assert property (axi_rsp_out.rvalid && (ra_q >= 8'hC0 || (ra_q > 8'h08
      && ra_q < 8'h40)) |-> axi_rsp_out.rresp == `RESP_SLVERR) else $error("unmapped read ok");
   AST_CONTACT_QUIET: assert property (
      !(cycle_strobe_in && run_mode_in) |=> $stable(contact_out))
      else $error("contact moved without a program cycle");
endmodule : relay_counter_checker
bind relay_updown_freq_counter relay_counter_checker relay_counter_checker_inst (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cycle_strobe_in(cycle_strobe_in),
   .run_mode_in(run_mode_in), .contact_out(contact_out), .axi_req_in(axi_req_in),
   .axi_rsp_out(axi_rsp_out));
`default_nettype wire

// file: verif/pulse_source.sv
// square-wave source driving both fast input pins
`timescale 1ns/1ps
`default_nettype none
module pulse_source #(
   parameter int HALF_A = 10,
   parameter int HALF_B = 25
) (
   // clock and control
   input wire logic clk_in,
   input wire logic run_in,
   // fast input pins
   output logic pin_a_out,
   output logic pin_b_out
);
   int cnt_a = 0;
   int cnt_b = 0;
   // 1:1 square waves, low when idle, off the sampling edge
   always @(negedge clk_in) begin
      cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
      cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
      pin_a_out <= run_in & (pin_a_out ^ (cnt_a == HALF_A - 1));
      pin_b_out <= run_in & (pin_b_out ^ (cnt_b == HALF_B - 1));
   end
endmodule : pulse_source
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench of the counter relay block
`timescale 1ns/1ps
`default_nettype none
`include "relay_counter_regs.svh"
module tb_top;
   import relay_counter_pkg::*;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic cycle_strobe_in = 1'b0;
   logic run_mode_in = 1'b0;
   logic src_run = 1'b0;
   logic pin_a;
   logic pin_b;
   logic [`NUM_CNT-1:0] contact_out;
   coil_bus_t coils_in = '0;
   axi_req_t req = '0;
   axi_rsp_t rsp;
   logic [15:0] rnd = 16'h540C;
   rd_result_t exp_q[$];
   rd_result_t got;
   int n_errors = 0;
   int total_checks = 0;
   relay_updown_freq_counter #(.GATE_CYCLES(100)) relay_updown_freq_counter_inst (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cycle_strobe_in(cycle_strobe_in),
      .run_mode_in(run_mode_in), .coils_in(coils_in), .contact_out(contact_out),
      .fast_input_a_in(pin_a), .fast_input_b_in(pin_b), .axi_req_in(req), .axi_rsp_out(rsp));
   pulse_source pulse_source_inst (.clk_in(clk_in), .run_in(src_run), .pin_a_out(pin_a),
      .pin_b_out(pin_b));
   initial forever #50 clk_in = ~clk_in;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   task end_sim;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task guard(input logic ok);
      if (ok !== 1'b1) begin
         $display("Error handshake expected 1 seen 0");
         n_errors++;
         end_sim();
      end
   endtask : guard
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      for (i = 0; i < 200 && rsp.awready !== 1'b1; i++) @(posedge clk_in);
      guard(rsp.awready);
      req.awvalid <= 1'b0;
      req.wvalid <= 1'b0;
      for (i = 0; i < 200 && rsp.bvalid !== 1'b1; i++) @(posedge clk_in);
      guard(rsp.bvalid);
      total_checks++;
      if (rsp.bresp !== `RESP_OKAY) begin
         $display("Error bresp expected %h seen %h", `RESP_OKAY, rsp.bresp);
         n_errors++;
      end
      req.bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
      int i;
      @(posedge clk_in);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      exp_q.push_back({r, d});
      for (i = 0; i < 200 && rsp.arready !== 1'b1; i++) @(posedge clk_in);
      guard(rsp.arready);
      req.arvalid <= 1'b0;
      for (i = 0; i < 200 && rsp.rvalid !== 1'b1; i++) @(posedge clk_in);
      guard(rsp.rvalid);
      req.rready <= 1'b0;
   endtask : rd
   // one program cycle with the given coils
   task cyc(input logic [15:0] c, input logic [15:0] d, input logic [15:0] r);
      @(posedge clk_in);
      coils_in <= {c, d, r};
      cycle_strobe_in <= 1'b1;
      @(posedge clk_in);
      cycle_strobe_in <= 1'b0;
   endtask : cyc
   // one count edge, at the sampling limit of one program cycle on and one off
   task pls(input logic [15:0] m, input logic [15:0] d);
      cyc(m, d, 16'h0000);
      cyc(16'h0000, d, 16'h0000);
   endtask : pls
   // compare each read answer with the oldest note
   always @(posedge clk_in) begin
      if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
         got = exp_q.pop_front();
         total_checks++;
         if (got !== {rsp.rresp, rsp.rdata}) begin
            $display("Error read expected %h seen %h", got, {rsp.rresp, rsp.rdata});
            n_errors++;
         end
      end
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      wr(8'h00, 32'hFFFF);
      rd(8'h00, 32'hF0F0);
      rnd = lfsr(rnd) & 16'h3FFF | 16'h0001;
      wr(8'h44, {16'h0000, rnd});
      rd(8'h44, {16'h0000, rnd});
      wr(8'h48, 32'hFFFF);
      rd(8'h48, 32'h7D00);
      rd(8'hC0, 32'h0, `RESP_SLVERR);
      rd(8'h0C, 32'h0, `RESP_SLVERR);
      wr(8'h40, 32'h2);
      run_mode_in <= 1'b1;
      pls(16'h0001, 16'h0000);
      pls(16'h0001, 16'h0000);
      rd(8'h80, 32'h2);
      rd(8'h08, 32'hFFF9);
      pls(16'h0001, 16'hFFFF);
      rd(8'h08, 32'hFFF8);
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         cyc(16'h0000, rnd, 16'h0000);
      end
      rd(8'h80, 32'h1);
      pls(16'h0001, 16'hFFFF);
      pls(16'h0001, 16'hFFFF);
      rd(8'h80, 32'h0);
      pls(16'h0001, 16'h0000);
      rd(8'h80, 32'h1);
      cyc(16'h0001, 16'h0000, 16'h0001);
      cyc(16'h0000, 16'h0000, 16'h0000);
      rd(8'h80, 32'h0);
      pls(16'h0011, 16'h0000);
      pls(16'h0011, 16'h0000);
      run_mode_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      run_mode_in <= 1'b1;
      rd(8'h80, 32'h0);
      rd(8'h90, 32'h2);
      wr(8'h04, 32'h3);
      wr(8'h78, 32'h4);
      src_run <= 1'b1;
      cyc(16'hC000, 16'hC000, 16'h0000);
      repeat (250) @(posedge clk_in);
      rd(8'hB8, 32'h5);
      rd(8'hBC, 32'h2);
      cyc(16'hC000, 16'h0000, 16'hC000);
      rd(8'hB8, 32'h0);
      cyc(16'hC000, 16'h0000, 16'h0000);
      repeat (250) @(posedge clk_in);
      cyc(16'hC000, 16'h0000, 16'h0000);
      rd(8'h08, 32'hFFF8);
      total_checks++;
      if (contact_out !== 16'hFFF8) begin
         $display("Error contact_out expected fff8 seen %h", contact_out);
         n_errors++;
      end
      cyc(16'h0000, 16'h0000, 16'h0000);
      rd(8'hB8, 32'h0);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
